// ===== core/mfsb_pkg.sv
// constants of the monitor flag and status byte bank
// assumes one clock domain and a byte-wide register port
package mfsb_pkg;
    // ------------------------------------------------------------------
    // channels and widths
    // ------------------------------------------------------------------
    localparam int MFSB_NCH       = 5;
    localparam int MFSB_MEAS_W    = 16;
    localparam int MFSB_CH_TEMP   = 0;
    localparam int MFSB_CH_SUPPLY = 1;
    localparam int MFSB_CH_FIRST_MONITOR_INPUT   = 2;
    localparam int MFSB_CH_SECOND_MONITOR_INPUT   = 3;
    localparam int MFSB_CH_THIRD_MONITOR_INPUT   = 4;

    // ------------------------------------------------------------------
    // per-channel flag positions
    // ------------------------------------------------------------------
    localparam int MFSB_FL_HI_ALM = 3;
    localparam int MFSB_FL_LO_ALM = 2;
    localparam int MFSB_FL_HI_WRN = 1;
    localparam int MFSB_FL_LO_WRN = 0;

    // ------------------------------------------------------------------
    // byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] MFSB_OFS_ALARM_SECOND = 8'h71;
    localparam logic [7:0] MFSB_OFS_RSVD_A       = 8'h72;
    localparam logic [7:0] MFSB_OFS_FAST_TRIP    = 8'h73;
    localparam logic [7:0] MFSB_OFS_WARN_FIRST   = 8'h74;
    localparam logic [7:0] MFSB_OFS_WARN_SECOND  = 8'h75;
    localparam logic [7:0] MFSB_OFS_RSVD_B       = 8'h76;
    localparam logic [7:0] MFSB_OFS_CONV_UPDATE  = 8'h77;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MFSB_THIRD_HI_BIT = 7;
    localparam int MFSB_THIRD_LO_BIT = 6;
    localparam int MFSB_IRQ_BIT      = 0;
    localparam int MFSB_TRIP_W       = 5;
    localparam int MFSB_TRIP_HBW_BIT = 4;
    localparam int MFSB_TRIP_HBA_BIT = 3;
    localparam int MFSB_TRIP_LOS_BIT = 2;
    localparam int MFSB_TRIP_LTX_BIT = 1;
    localparam int MFSB_TRIP_HTX_BIT = 0;
    localparam int MFSB_UPD_TOP_BIT  = 7;
    localparam int MFSB_RANGE_BIT    = 0;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [4:0] MFSB_TRIP_RST  = 5'h00;
    localparam logic [4:0] MFSB_UPD_RST   = 5'h00;
    localparam logic [7:0] MFSB_RDATA_RST = 8'h00;
    localparam logic [3:0] MFSB_FLAG_RST  = 4'h0;
endpackage : mfsb_pkg

// ===== core/mfsb_chan_if.sv
// carrier between the bank and one channel limit comparator
// assumes the bank drives measurement, limits and done pulse
interface mfsb_chan_if #(
    parameter int W = 16
);
    logic [W-1:0] meas;
    logic [W-1:0] hi_alm_lim;
    logic [W-1:0] lo_alm_lim;
    logic [W-1:0] hi_wrn_lim;
    logic [W-1:0] lo_wrn_lim;
    logic         done;
    logic [3:0]   flags;
    logic         valid;

    modport src (output meas, hi_alm_lim, lo_alm_lim, hi_wrn_lim,
                 output lo_wrn_lim, done, input flags, valid);
    modport cmp (input meas, hi_alm_lim, lo_alm_lim, hi_wrn_lim,
                 input lo_wrn_lim, done, output flags, valid);
endinterface : mfsb_chan_if

// ===== core/mfsb_limit_cmp.sv
// one channel: compares each finished conversion against four limits
// assumes done is a one-cycle pulse with meas stable in that cycle
module mfsb_limit_cmp #(
    parameter bit SIGNED_CMP = 1'b0
) (
    input  wire logic  clock_i,
    input  wire logic  rst_b_i,
    input  wire logic  ce_i,
    mfsb_chan_if.cmp   ch
);
    import mfsb_pkg::*;

    typedef struct packed {
        logic [3:0] flags;
        logic       valid;
    } mfsb_cmp_state_t;

    mfsb_cmp_state_t st_reg;
    mfsb_cmp_state_t st_next;

    function automatic logic above(input logic [31:0] a,
                                   input logic [31:0] b);
        if (SIGNED_CMP) begin
            return $signed(a) > $signed(b);
        end
        return a > b;
    endfunction : above

    always_comb begin
        st_next = st_reg;
        // flags stay cleared until the first conversion lands
        // widen by sign: keeps two's complement order, and unsigned
        // order too, so one widening serves both compare kinds
        if (ce_i && ch.done) begin
            st_next.valid = 1'b1;
            st_next.flags[MFSB_FL_HI_ALM] =
                above(32'($signed(ch.meas)), 32'($signed(ch.hi_alm_lim)));
            st_next.flags[MFSB_FL_LO_ALM] =
                above(32'($signed(ch.lo_alm_lim)), 32'($signed(ch.meas)));
            st_next.flags[MFSB_FL_HI_WRN] =
                above(32'($signed(ch.meas)), 32'($signed(ch.hi_wrn_lim)));
            st_next.flags[MFSB_FL_LO_WRN] =
                above(32'($signed(ch.lo_wrn_lim)), 32'($signed(ch.meas)));
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st_reg <= '{flags: MFSB_FLAG_RST, valid: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign ch.flags = st_reg.flags;
    assign ch.valid = st_reg.valid;
endmodule : mfsb_limit_cmp

// ===== core/mfsb_trip_latch.sv
// fast-trip flag holder, live or latched with write-zero clear
// assumes comparator levels are synchronous to clock_i
module mfsb_trip_latch (
    input  wire logic                               clock_i,
    input  wire logic                               rst_b_i,
    input  wire logic                               ce_i,
    input  wire logic [mfsb_pkg::MFSB_TRIP_W-1:0]   level_i,
    input  wire logic                               latch_en_i,
    input  wire logic                               clr_we_i,
    input  wire logic [mfsb_pkg::MFSB_TRIP_W-1:0]   clr_data_i,
    output logic      [mfsb_pkg::MFSB_TRIP_W-1:0]   flags_o
);
    import mfsb_pkg::*;

    typedef struct packed {
        logic [MFSB_TRIP_W-1:0] flags;
    } mfsb_trip_state_t;

    mfsb_trip_state_t       st_reg;
    mfsb_trip_state_t       st_next;
    logic [MFSB_TRIP_W-1:0] clr;

    assign clr = clr_we_i ? ~clr_data_i : '0;

    always_comb begin
        st_next = st_reg;
        if (ce_i) begin
            if (latch_en_i) begin
                // a live trip in the clearing cycle keeps its flag
                st_next.flags = (st_reg.flags & ~clr) | level_i;
            end else begin
                st_next.flags = level_i;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st_reg <= '{flags: MFSB_TRIP_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags_o = st_reg.flags;
endmodule : mfsb_trip_latch

// ===== core/mfsb_bank.sv
// monitor flag and status byte bank: alarm, warning, fast-trip and
// conversion-update bytes with maskable interrupt
// assumes a byte register port already decoded from the serial link
// Function
// - third input high alarm flag follows measurement above high limit
// - third input low alarm flag follows measurement below low limit
// - interrupt bit is OR of all enabled alarm and warning flags
// - a select bit chooses which of two four-byte mask sets applies
// - all-zero active mask set forces the interrupt bit to zero
// - flags stay zero until the channel's first conversion
// - fast-trip byte resets to zero, top three bits read zero
// - bit 4 shows bias above high bias warning limit
// - bit 3 shows bias above high bias alarm limit
// - bit 2 shows loss-of-signal measurement below its limit
// - bit 1 shows received power below low transmit power limit
// - bit 0 shows received power above high transmit power limit
// - latched trip flags hold until host writes them to zero
// - warning bits 7 and 6 track temperature high and low limits
// - warning bits 5 and 4 track supply high and low limits
// - warning bits 3 and 2 track first input high and low limits
// - warning bits 1 and 0 track second input high and low limits
// - second warning byte bits 7 and 6 track third input limits
// - update bits set after each conversion of their channel
// - host-cleared update bit stays zero until next conversion
// - update byte bits 2 and 1 read zero, bits 7 to 3 reset to zero
// - update byte bit 0 reports fine or coarse received power range
// - mask bit one lets its flag reach the interrupt, zero blocks
module mfsb_bank #(
    parameter int MEAS_W = mfsb_pkg::MFSB_MEAS_W
) (
    input  wire logic                                    clock_i,
    input  wire logic                                    rst_b_i,
    input  wire logic                                    ce_i,
    input  wire logic [mfsb_pkg::MFSB_NCH-1:0][MEAS_W-1:0] meas_i,
    input  wire logic [mfsb_pkg::MFSB_NCH-1:0]           conv_done_i,
    input  wire logic [mfsb_pkg::MFSB_NCH-1:0][MEAS_W-1:0] hi_alm_lim_i,
    input  wire logic [mfsb_pkg::MFSB_NCH-1:0][MEAS_W-1:0] lo_alm_lim_i,
    input  wire logic [mfsb_pkg::MFSB_NCH-1:0][MEAS_W-1:0] hi_wrn_lim_i,
    input  wire logic [mfsb_pkg::MFSB_NCH-1:0][MEAS_W-1:0] lo_wrn_lim_i,
    input  wire logic [mfsb_pkg::MFSB_TRIP_W-1:0]        trip_level_i,
    input  wire logic                                    trip_latch_en_i,
    input  wire logic [31:0]                             mask_set_a_i,
    input  wire logic [31:0]                             mask_set_b_i,
    input  wire logic                                    mask_set_sel_i,
    input  wire logic                                    rx_power_range_i,
    input  wire logic [7:0]                              reg_addr_i,
    input  wire logic                                    reg_wr_i,
    input  wire logic                                    reg_rd_i,
    input  wire logic [7:0]                              reg_wdata_i,
    output logic      [7:0]                              reg_rdata_o,
    output logic                                         maskable_irq_o,
    output logic      [mfsb_pkg::MFSB_TRIP_W-1:0]        trip_flags_o
);
    import mfsb_pkg::*;

    typedef struct packed {
        logic [7:0]          rdata;
        logic                irq;
        logic [MFSB_NCH-1:0] upd;
    } mfsb_bank_state_t;

    mfsb_bank_state_t          st_reg;
    mfsb_bank_state_t          st_next;
    logic [MFSB_NCH-1:0][3:0]  chan_flags;
    logic [MFSB_NCH-1:0]       chan_valid;
    logic [7:0]                alarm_first;
    logic [7:0]                alarm_second;
    logic [7:0]                warn_first;
    logic [7:0]                warn_second;
    logic [7:0]                upd_byte;
    logic [31:0]               flag_vec;
    logic [31:0]               mask_act;
    logic                      irq_calc;
    logic [7:0]                rd_mux;
    logic                      wr_trip;
    logic                      wr_upd;
    logic [MFSB_TRIP_W-1:0]    trip_flags;

    // ------------------------------------------------------------------
    // per-channel limit comparators
    // ------------------------------------------------------------------
    for (genvar i = 0; i < MFSB_NCH; i++) begin : g_chan
        mfsb_chan_if #(.W(MEAS_W)) chan ();

        assign chan.meas       = meas_i[i];
        assign chan.hi_alm_lim = hi_alm_lim_i[i];
        assign chan.lo_alm_lim = lo_alm_lim_i[i];
        assign chan.hi_wrn_lim = hi_wrn_lim_i[i];
        assign chan.lo_wrn_lim = lo_wrn_lim_i[i];
        assign chan.done       = conv_done_i[i];
        assign chan_flags[i]   = chan.flags;
        assign chan_valid[i]   = chan.valid;

        // temperature is two's complement, the rest unsigned
        mfsb_limit_cmp #(
            .SIGNED_CMP (i == MFSB_CH_TEMP)
        ) u_cmp (
            .clock_i (clock_i),
            .rst_b_i (rst_b_i),
            .ce_i    (ce_i),
            .ch      (chan)
        );

        if (i < MFSB_CH_THIRD_MONITOR_INPUT) begin : g_first
            assign alarm_first[7-2*i] = chan.flags[MFSB_FL_HI_ALM];
            assign alarm_first[6-2*i] = chan.flags[MFSB_FL_LO_ALM];
            assign warn_first[7-2*i]  = chan.flags[MFSB_FL_HI_WRN];
            assign warn_first[6-2*i]  = chan.flags[MFSB_FL_LO_WRN];
        end
        assign upd_byte[MFSB_UPD_TOP_BIT-i] = st_reg.upd[i];
    end

    // ------------------------------------------------------------------
    // status byte assembly
    // ------------------------------------------------------------------
    assign alarm_second = {chan_flags[MFSB_CH_THIRD_MONITOR_INPUT][MFSB_FL_HI_ALM],
                           chan_flags[MFSB_CH_THIRD_MONITOR_INPUT][MFSB_FL_LO_ALM],
                           5'h00, st_reg.irq};
    assign warn_second  = {chan_flags[MFSB_CH_THIRD_MONITOR_INPUT][MFSB_FL_HI_WRN],
                           chan_flags[MFSB_CH_THIRD_MONITOR_INPUT][MFSB_FL_LO_WRN],
                           6'h00};
    assign upd_byte[2:1]          = 2'h0;
    assign upd_byte[MFSB_RANGE_BIT] = rx_power_range_i;

    // ------------------------------------------------------------------
    // maskable interrupt
    // ------------------------------------------------------------------
    assign mask_act = mask_set_sel_i ? mask_set_b_i : mask_set_a_i;
    assign flag_vec = {alarm_first, alarm_second[7:6], 6'h00,
                       warn_first, warn_second[7:6], 6'h00};
    // zero masks give zero here as well
    assign irq_calc = |(flag_vec & mask_act);

    // ------------------------------------------------------------------
    // fast-trip flags
    // ------------------------------------------------------------------
    assign wr_trip = ce_i && reg_wr_i && (reg_addr_i == MFSB_OFS_FAST_TRIP);

    // level bits arrive in byte order
    mfsb_trip_latch u_trip (
        .clock_i    (clock_i),
        .rst_b_i    (rst_b_i),
        .ce_i       (ce_i),
        .level_i    (trip_level_i),
        .latch_en_i (trip_latch_en_i),
        .clr_we_i   (wr_trip),
        .clr_data_i (reg_wdata_i[MFSB_TRIP_W-1:0]),
        .flags_o    (trip_flags)
    );

    // ------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------
    always_comb begin
        unique case (reg_addr_i)
            MFSB_OFS_ALARM_SECOND: rd_mux = alarm_second;
            MFSB_OFS_FAST_TRIP:    rd_mux = {3'h0, trip_flags};
            MFSB_OFS_WARN_FIRST:   rd_mux = warn_first;
            MFSB_OFS_WARN_SECOND:  rd_mux = warn_second;
            MFSB_OFS_CONV_UPDATE:  rd_mux = upd_byte;
            default:               rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // bank state
    // ------------------------------------------------------------------
    assign wr_upd = reg_wr_i && (reg_addr_i == MFSB_OFS_CONV_UPDATE);

    // writes to alarm and warning bytes have no path into state
    always_comb begin
        st_next = st_reg;
        if (ce_i) begin
            st_next.irq = irq_calc;
            for (int i = 0; i < MFSB_NCH; i++) begin
                // a conversion in the clearing cycle wins
                st_next.upd[i] = (st_reg.upd[i] &
                    ~(wr_upd & ~reg_wdata_i[MFSB_UPD_TOP_BIT-i])) |
                    conv_done_i[i];
            end
            if (reg_rd_i) begin
                st_next.rdata = rd_mux;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st_reg <= '{rdata: MFSB_RDATA_RST, irq: 1'b0,
                        upd: MFSB_UPD_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o    = st_reg.rdata;
    assign maskable_irq_o = st_reg.irq;
    assign trip_flags_o   = trip_flags;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    logic [MEAS_W-1:0] third_monitor_input_meas;
    logic [MEAS_W-1:0] third_monitor_input_hi_alm;
    logic [MEAS_W-1:0] third_monitor_input_lo_alm;
    logic [MEAS_W-1:0] first_monitor_input_meas;
    logic [MEAS_W-1:0] first_monitor_input_hi_wrn;
    logic              third_monitor_input_done;
    logic              first_monitor_input_done;

    assign third_monitor_input_meas   = meas_i[MFSB_CH_THIRD_MONITOR_INPUT];
    assign third_monitor_input_hi_alm = hi_alm_lim_i[MFSB_CH_THIRD_MONITOR_INPUT];
    assign third_monitor_input_lo_alm = lo_alm_lim_i[MFSB_CH_THIRD_MONITOR_INPUT];
    assign first_monitor_input_meas   = meas_i[MFSB_CH_FIRST_MONITOR_INPUT];
    assign first_monitor_input_hi_wrn = hi_wrn_lim_i[MFSB_CH_FIRST_MONITOR_INPUT];
    assign third_monitor_input_done   = conv_done_i[MFSB_CH_THIRD_MONITOR_INPUT];
    assign first_monitor_input_done   = conv_done_i[MFSB_CH_FIRST_MONITOR_INPUT];

    chk_third_alarm_hi: assert property (
        ce_i && third_monitor_input_done |=> alarm_second[7] ==
            ($past(third_monitor_input_meas) > $past(third_monitor_input_hi_alm)))
        else $error("third input high alarm wrong");
    chk_third_alarm_lo: assert property (
        ce_i && third_monitor_input_done |=> alarm_second[6] ==
            ($past(third_monitor_input_meas) < $past(third_monitor_input_lo_alm)))
        else $error("third input low alarm wrong");
    chk_irq_or_value: assert property (
        ce_i |=> maskable_irq_o == $past(irq_calc))
        else $error("interrupt bit not the masked OR");
    chk_mask_set_b: assert property (
        ce_i && mask_set_sel_i && (mask_set_b_i == 32'h0000_0000)
        |=> !maskable_irq_o)
        else $error("second mask set not applied");
    chk_mask_all_zero: assert property (
        ce_i && (mask_act == 32'h0000_0000) [*2] |=> !maskable_irq_o)
        else $error("interrupt set with zero masks");
    chk_flag_before_conv: assert property (
        !chan_valid[MFSB_CH_THIRD_MONITOR_INPUT] |-> (chan_flags[MFSB_CH_THIRD_MONITOR_INPUT] == 4'h0))
        else $error("flag set before first conversion");
    chk_trip_top_zero: assert property (
        ce_i && reg_rd_i && (reg_addr_i == MFSB_OFS_FAST_TRIP)
        |=> reg_rdata_o[7:5] == 3'h0)
        else $error("fast-trip top bits not zero");
    chk_trip_live: assert property (
        ce_i && !trip_latch_en_i |=> trip_flags_o == $past(trip_level_i))
        else $error("live trip flags wrong");
    chk_trip_held: assert property (
        ce_i && trip_latch_en_i && trip_flags_o[MFSB_TRIP_HBW_BIT] &&
        !(wr_trip && !reg_wdata_i[MFSB_TRIP_HBW_BIT])
        |=> trip_flags_o[MFSB_TRIP_HBW_BIT])
        else $error("latched trip flag lost");
    chk_first_warn_hi: assert property (
        ce_i && first_monitor_input_done |=> warn_first[3] ==
            ($past(first_monitor_input_meas) > $past(first_monitor_input_hi_wrn)))
        else $error("first input high warning wrong");
    chk_update_set: assert property (
        ce_i && third_monitor_input_done |=> upd_byte[3])
        else $error("update bit not set");
    chk_update_cleared: assert property (
        ce_i && wr_upd && !reg_wdata_i[5] && !first_monitor_input_done
        |=> !upd_byte[5])
        else $error("update bit not cleared");
    chk_update_reserved: assert property (
        ce_i && reg_rd_i && (reg_addr_i == MFSB_OFS_CONV_UPDATE)
        |=> (reg_rdata_o[2:1] == 2'h0) &&
            (reg_rdata_o[0] == $past(rx_power_range_i)))
        else $error("update byte low bits wrong");

    cov_trip_clear: cover property (
        trip_latch_en_i && trip_flags_o[0] ##1 !trip_flags_o[0]);
    cov_update_cycle: cover property (
        wr_upd && !reg_wdata_i[7] ##[1:20] upd_byte[7]);
    cov_irq_rise: cover property (!maskable_irq_o ##1 maskable_irq_o);
endmodule : mfsb_bank

// ===== tb/mfsb_host_model.sv
// host model: byte reads and writes on the decoded register port
// assumes read data is valid one cycle after the taken edge
module mfsb_host_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge clock_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        // the byte launched at the taken edge stands through this cycle
        @(posedge clock_i);
        d = reg_rdata_i;
    endtask : rd
    // a zero written to a flag is how the host clears it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        @(posedge clock_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask : wr
endmodule : mfsb_host_model

// ===== tb/test_monitor_flag_status_bank.sv
// self-checking bench of the monitor flag and status byte bank
// assumes the host model drives the register port
module test_monitor_flag_status_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import mfsb_pkg::*;
    logic clock_i = 1'b0, rst_b_i = 1'b0, lat = 1'b0, sel = 1'b0;
    logic rng = 1'b0, irq, ce = 1'b1;
    logic [MFSB_NCH-1:0][MFSB_MEAS_W-1:0] meas = '0, ha, la, hw, lw;
    logic [MFSB_NCH-1:0] done = '0;
    logic [MFSB_TRIP_W-1:0] lvl = '0, trip;
    logic [31:0] mska = '0, mskb = '0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    always #5 clock_i = ~clock_i;
    initial for (int i = 0; i < MFSB_NCH; i++) begin
        ha[i] = 16'h03E8;
        la[i] = 16'h0064;
        hw[i] = 16'h0320;
        lw[i] = 16'h00C8;
    end
    mfsb_bank uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .meas_i(meas), .conv_done_i(done), .hi_alm_lim_i(ha),
        .lo_alm_lim_i(la), .hi_wrn_lim_i(hw), .lo_wrn_lim_i(lw),
        .trip_level_i(lvl), .trip_latch_en_i(lat), .mask_set_a_i(mska),
        .mask_set_b_i(mskb), .mask_set_sel_i(sel),
        .rx_power_range_i(rng), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .maskable_irq_o(irq), .trip_flags_o(trip));
    mfsb_host_model host (.clock_i(clock_i), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
        .reg_wdata_o(wdata));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic check(input string n, input logic [7:0] s, e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic rdchk(input logic [7:0] a, e);
        logic [7:0] d;
        host.rd(a, d);
        check($sformatf("reg %h", a), d, e);
    endtask : rdchk
    task automatic conv(input int ch, input logic [15:0] m);
        @(posedge clock_i);
        meas[ch] <= m;
        done[ch] <= 1'b1;
        @(posedge clock_i);
        done <= '0;
    endtask : conv
    task automatic reset_values();
        rdchk(8'h73, 8'h00);
        rdchk(8'h77, 8'h00);
        rdchk(8'h74, 8'h00);
        check("irq", {7'h00, irq}, 8'h00);
    endtask : reset_values
    task automatic flags();
        conv(0, 900);
        conv(1, 150);
        conv(2, 2000);
        conv(3, 50);
        conv(4, 1100);
        rdchk(8'h74, 8'h99);
        rdchk(8'h71, 8'h80);
        rdchk(8'h75, 8'h80);
        conv(4, 800);
        rdchk(8'h75, 8'h00);
        rdchk(8'h71, 8'h00);
        conv(4, 50);
        rdchk(8'h71, 8'h40);
        rdchk(8'h75, 8'h40);
        conv(0, 500);
        rdchk(8'h74, 8'h19);
    endtask : flags
    task automatic updates();
        rdchk(8'h77, 8'hF8);
        host.wr(8'h77, 8'h00);
        rdchk(8'h77, 8'h00);
        rng <= 1'b1;
        conv(2, 2000);
        rdchk(8'h77, 8'h21);
    endtask : updates
    task automatic irq_masks();
        logic [31:0] a[5] = '{32'h0, 32'h0040_0000, 32'hFFFF_FFFF,
                              32'h0, 32'h0000_8000};
        logic [31:0] b[5] = '{32'hFFFF_FFFF, 32'h0, 32'h0,
                              32'h0000_0100, 32'h0};
        logic s[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic e[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            @(posedge clock_i);
            mska <= a[i];
            mskb <= b[i];
            sel  <= s[i];
            repeat (3) @(posedge clock_i);
            check("irq", {7'h00, irq}, {7'h00, e[i]});
            rdchk(8'h71, {7'h20, e[i]});
        end
    endtask : irq_masks
    task automatic fast_trip();
        for (int i = 0; i < MFSB_TRIP_W; i++) begin
            @(posedge clock_i);
            lvl <= 5'h01 << i;
            repeat (2) @(posedge clock_i);
            check("trip", {3'h0, trip}, 8'h01 << i);
            rdchk(8'h73, 8'h01 << i);
        end
        lat <= 1'b1;
        lvl <= 5'h15;
        @(posedge clock_i);
        lvl <= 5'h00;
        repeat (2) @(posedge clock_i);
        rdchk(8'h73, 8'h15);
        host.wr(8'h73, 8'hFF);
        rdchk(8'h73, 8'h15);
        host.wr(8'h73, 8'h00);
        rdchk(8'h73, 8'h00);
    endtask : fast_trip
    task automatic writes_ignored();
        logic [7:0] a[6] = '{8'h71, 8'h72, 8'h74, 8'h75, 8'h76, 8'h78};
        logic [7:0] e[6] = '{8'h40, 8'h00, 8'h19, 8'h40, 8'h00, 8'h00};
        foreach (a[i]) host.wr(a[i], 8'hFF);
        foreach (a[i]) rdchk(a[i], e[i]);
    endtask : writes_ignored
    // a conversion taken with the enable low must leave no trace
    task automatic freeze_and_sign();
        @(posedge clock_i);
        ce <= 1'b0;
        conv(0, 16'h0384);
        ce <= 1'b1;
        rdchk(8'h74, 8'h19);
        rdchk(8'h77, 8'h21);
        conv(0, 16'hFFFF);
        rdchk(8'h74, 8'h59);
    endtask : freeze_and_sign
    initial begin
        repeat (8) @(posedge clock_i);
        rst_b_i <= 1'b1;
        reset_values();
        flags();
        updates();
        irq_masks();
        fast_trip();
        writes_ignored();
        freeze_and_sign();
        report_and_stop();
    end
endmodule : test_monitor_flag_status_bank
